// ### design/bbs_setup_bank.sv
// Window setup register bank: aperture size masking, enables and translated bases
//
// Contract
// - Six-bit size field at 9:4, read-write, resets to 0x01; size 2^value.
// - Base field bit 0 is bus address bit 4.
// - Size zero makes every base-address bit writable.
// - Nonzero size: bits at or above size writable; lower bits read zero.
// - Nonzero size below four forces whole base field to read-only zero.
// - I/O windows down to 16 bytes, size value 4, are supported.
// - Without 64-bit width, size effect above address bit 32 is ignored.
// - Enable bit 31 resets clear; disabled window base reads zero.
// - Enable and other sticky setup fields survive hot reset; cold (fundamental) reset clears them.
// - Setup bits 30:10 read zero and ignore writes.
// - Window 0 memory 64-bit: window-1 translated base is its upper half.
// - In that pairing all 32 translated-base bits are read-write.
// - In that pairing window-1 setup reads zero; window 1 is upper base.
// - Width code 0x0 is 32-bit, 0x2 is 64-bit, others reserved.
// - Space bit 0 memory, 1 I/O; I/O forces width to zero.
//
// Chosen here: the AHB-Lite register port.
`timescale 1ns/1ns
module bbs_setup_bank import bbs_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic cold_rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic pair_mode,
  output bbs_win_t win0,
  output bbs_win_t win1
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bbs_state_t q;
  bbs_state_t d;
  logic pair;
  logic accept;
  logic [BASE_BITS-1:0] mask0;
  logic [BASE_BITS-1:0] mask1;
  logic [31:0] rd_word;

  // Window 0 in memory space with 64-bit width swallows window 1
  assign pair = (q.w0_setup.space == SPACE_MEM) && (q.w0_setup.width == WIDTH_64);
  assign accept = hsel && hready && htrans[1];

  bbs_mask u_mask0 (
    .size(q.w0_setup.size),
    .wide(pair),
    .writable(mask0)
  );

  // Window 1 never addresses 64 bits on its own
  bbs_mask u_mask1 (
    .size(q.w1_setup.size),
    .wide(1'b0),
    .writable(mask1)
  );

  // ----------------------------------------------------------------
  // Field packing
  // ----------------------------------------------------------------
  function automatic bbs_setup_t setup_from(input logic [31:0] v);
    bbs_setup_t s;
    s.en = v[EN_BIT];
    s.size = v[SIZE_LSB +: 6];
    s.pref = v[PREF_BIT];
    s.space = v[SPACE_BIT];
    s.width = v[SPACE_BIT] ? WIDTH_32 : v[WIDTH_LSB +: 2];
    return s;
  endfunction : setup_from

  function automatic logic [31:0] setup_word(input bbs_setup_t s);
    return {s.en, 21'h000000, s.size, s.pref, s.width, s.space};
  endfunction : setup_word

  function automatic logic [3:0] type_bits(input bbs_setup_t s);
    return {s.pref, s.width, s.space};
  endfunction : type_bits

  // ----------------------------------------------------------------
  // Read mux, sampled during the read wait state
  // ----------------------------------------------------------------
  always_comb begin
    rd_word = 32'h0;
    if (q.addr == OFS_W0_SETUP) begin
      rd_word = setup_word(q.w0_setup);
    end else if (q.addr == OFS_W1_SETUP) begin
      rd_word = pair ? 32'h0 : setup_word(q.w1_setup);
    end else if (q.addr == OFS_W0_TBASE) begin
      rd_word = {q.w0_tbase[31:4], 4'h0};
    end else if (q.addr == OFS_W1_TBASE) begin
      rd_word = pair ? q.w1_tbase : {q.w1_tbase[31:4], 4'h0};
    end else if (q.addr == OFS_W0_BASE) begin
      if (q.w0_setup.en) begin
        rd_word = {q.w0_base[LOW_BITS-1:0], type_bits(q.w0_setup)};
      end
    end else if (q.addr == OFS_W1_BASE) begin
      if (pair) begin
        rd_word = q.w0_setup.en ? q.w0_base[BASE_BITS-1:LOW_BITS] : 32'h0;
      end else if (q.w1_setup.en) begin
        rd_word = {q.w1_base, type_bits(q.w1_setup)};
      end
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    if (q.bus == BUS_WRITE) begin
      if (q.addr == OFS_W0_SETUP) begin
        d.w0_setup = setup_from(hwdata);
      end else if (q.addr == OFS_W1_SETUP) begin
        if (!pair) begin
          d.w1_setup = setup_from(hwdata);
        end
      end else if (q.addr == OFS_W0_TBASE) begin
        d.w0_tbase = {hwdata[31:4], 4'h0};
      end else if (q.addr == OFS_W1_TBASE) begin
        d.w1_tbase = pair ? hwdata : {hwdata[31:4], 4'h0};
      end else if (q.addr == OFS_W0_BASE) begin
        if (q.w0_setup.en) begin
          d.w0_base[LOW_BITS-1:0] = hwdata[31:BASE_LSB];
        end
      end else if (q.addr == OFS_W1_BASE) begin
        if (pair && q.w0_setup.en) begin
          d.w0_base[BASE_BITS-1:LOW_BITS] = hwdata;
        end else if (!pair && q.w1_setup.en) begin
          d.w1_base = hwdata[31:BASE_LSB];
        end
      end
    end
    // Masked positions drop write data and are scrubbed after a size change
    d.w0_base = d.w0_base & mask0;
    d.w1_base = d.w1_base & mask1[LOW_BITS-1:0];
    if (q.bus == BUS_READ) begin
      d.rdata = rd_word;
    end
    if (accept) begin
      d.bus = hwrite ? BUS_WRITE : BUS_READ;
      d.addr = (haddr[31:8] == 24'h000000) ? {haddr[7:2], 2'b00} : 8'hFF;
    end else if (q.bus == BUS_READ) begin
      d.bus = BUS_RDONE;
    end else begin
      d.bus = BUS_IDLE;
    end
  end

  // ----------------------------------------------------------------
  // Registers; cold reset loads all reset values, warm reset spares sticky fields
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (cold_rst) begin
      q <= STATE_RST;
    end else if (rst) begin
      q <= d;
      q.w0_setup.size <= SIZE_RST;
      q.w1_setup.size <= SIZE_RST;
      q.w0_base <= '0;
      q.w1_base <= '0;
      q.bus <= BUS_IDLE;
      q.addr <= 8'h00;
      q.rdata <= 32'h0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // One wait state on reads keeps read data registered and fresh after a write
  assign hreadyout = (q.bus != BUS_READ);
  assign hresp = 1'b0;
  assign hrdata = q.rdata;
  assign pair_mode = pair;

  always_comb begin
    win0.en = q.w0_setup.en;
    win0.space = q.w0_setup.space;
    win0.width = q.w0_setup.width;
    win0.pref = q.w0_setup.pref;
    win0.base = {q.w0_base, 4'h0};
    win0.tbase = {pair ? q.w1_tbase : 32'h0, q.w0_tbase[31:4], 4'h0};
    win1.en = q.w1_setup.en && !pair;
    win1.space = q.w1_setup.space;
    win1.width = q.w1_setup.width;
    win1.pref = q.w1_setup.pref;
    win1.base = {32'h0, q.w1_base, 4'h0};
    win1.tbase = {32'h0, q.w1_tbase[31:4], 4'h0};
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_size_reset: assert property (@(posedge clk) disable iff (cold_rst)
    $fell(rst) |-> (q.w0_setup.size == SIZE_RST) && (q.w1_setup.size == SIZE_RST))
    else $error("size field not at reset value after reset");

  chk_zero_size: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.w0_setup.size == SIZE_ALL) && pair |-> (&mask0))
    else $error("size zero did not open every base bit");

  chk_base_masked: assert property (@(posedge clk) disable iff (rst || cold_rst)
    $stable(q.w0_setup) && $stable(q.w1_setup) |->
      ((q.w0_base & ~mask0) == '0) && ((q.w1_base & ~mask1[LOW_BITS-1:0]) == '0))
    else $error("base bit below size holds a one");

  chk_small_size: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.w1_setup.size != SIZE_ALL) && (q.w1_setup.size < SIZE_MIN_ON) |-> (mask1 == '0))
    else $error("small size left base bits writable");

  chk_io_window: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.w1_setup.size == SIZE_MIN_ON) |-> (&mask1[LOW_BITS-1:0]))
    else $error("16-byte window not fully writable");

  chk_cap_32: assert property (@(posedge clk) disable iff (rst || cold_rst)
    !pair && (q.w0_setup.size > SIZE_CAP32) |-> (mask0 == '0))
    else $error("size above 32 opened bits without 64-bit width");

  chk_read_disabled: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (accept && !hwrite && (haddr == 32'(OFS_W0_BASE))) ##1 !q.w0_setup.en |=>
      (hreadyout && (hrdata == 32'h0)))
    else $error("disabled window base read not zero");

  chk_sticky_en: assert property (@(posedge clk) disable iff (cold_rst)
    rst && (q.bus != BUS_WRITE) |=> $stable(q.w0_setup.en) && $stable(q.w1_setup.en))
    else $error("enable lost across warm reset");

  chk_reserved_zero: assert property (@(posedge clk) disable iff (rst || cold_rst)
    accept && !hwrite && (haddr == 32'(OFS_W0_SETUP)) |-> ##2 (hreadyout && (hrdata[30:10] == '0)))
    else $error("reserved setup bits read nonzero");

  chk_pair_tbase: assert property (@(posedge clk) disable iff (rst || cold_rst)
    pair |-> (win0.tbase[63:32] == q.w1_tbase))
    else $error("upper translated base not from window 1");

  chk_tbase_full: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.bus == BUS_WRITE) && (q.addr == OFS_W1_TBASE) |=>
      (q.w1_tbase == ($past(pair) ? $past(hwdata) : {$past(hwdata[31:4]), 4'h0})))
    else $error("window 1 translated base write wrong");

  chk_pair_setup: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (accept && !hwrite && (haddr == 32'(OFS_W1_SETUP))) ##1 pair |=> (hrdata == 32'h0))
    else $error("window 1 setup not zero in paired mode");

  chk_io_width: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.w0_setup.space == SPACE_IO) |-> (q.w0_setup.width == WIDTH_32) && !pair)
    else $error("I/O window kept a nonzero width");

  chk_write_masked: assert property (@(posedge clk) disable iff (rst || cold_rst)
    (q.bus == BUS_WRITE) && (q.addr == OFS_W1_BASE) && !pair && q.w1_setup.en |=>
      (q.w1_base == ($past(hwdata[31:4]) & $past(mask1[LOW_BITS-1:0]))))
    else $error("base write not masked by size");

endmodule : bbs_setup_bank

// ### pkg/bbs_pkg.sv
// Package: register map, field layout, reset values and state types of the window setup bank
package bbs_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_W0_BASE = 8'h10;
  localparam logic [7:0] OFS_W1_BASE = 8'h14;
  localparam logic [7:0] OFS_W0_SETUP = 8'h7C;
  localparam logic [7:0] OFS_W0_TBASE = 8'h80;
  localparam logic [7:0] OFS_W1_SETUP = 8'h84;
  localparam logic [7:0] OFS_W1_TBASE = 8'h88;

  // ----------------------------------------------------------------
  // Field positions and codes
  // ----------------------------------------------------------------
  localparam int SPACE_BIT = 0;
  localparam int WIDTH_LSB = 1;
  localparam int PREF_BIT = 3;
  localparam int SIZE_LSB = 4;
  localparam int EN_BIT = 31;
  localparam int BASE_LSB = 4;
  localparam int BASE_BITS = 60;
  localparam int LOW_BITS = 28;
  localparam logic [1:0] WIDTH_32 = 2'h0;
  localparam logic [1:0] WIDTH_64 = 2'h2;
  localparam logic SPACE_MEM = 1'h0;
  localparam logic SPACE_IO = 1'h1;
  localparam logic [5:0] SIZE_RST = 6'h01;
  localparam logic [5:0] SIZE_ALL = 6'h00;
  localparam logic [5:0] SIZE_MIN_ON = 6'h04;
  localparam logic [5:0] SIZE_CAP32 = 6'h20;
  localparam logic [3:0] TBASE_LOW_MASK = 4'hF;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic en;
    logic [5:0] size;
    logic pref;
    logic [1:0] width;
    logic space;
  } bbs_setup_t;

  typedef struct packed {
    logic en;
    logic space;
    logic [1:0] width;
    logic pref;
    logic [63:0] base;
    logic [63:0] tbase;
  } bbs_win_t;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WRITE = 2'b01,
    BUS_READ = 2'b10,
    BUS_RDONE = 2'b11
  } bbs_bus_t;

  typedef struct packed {
    bbs_setup_t w0_setup;
    bbs_setup_t w1_setup;
    logic [BASE_BITS-1:0] w0_base;
    logic [LOW_BITS-1:0] w1_base;
    logic [31:0] w0_tbase;
    logic [31:0] w1_tbase;
    bbs_bus_t bus;
    logic [7:0] addr;
    logic [31:0] rdata;
  } bbs_state_t;

  localparam bbs_setup_t SETUP_RST = '{en: 1'h0, size: SIZE_RST, pref: 1'h0, width: WIDTH_32, space: SPACE_MEM};
  localparam bbs_state_t STATE_RST = '{w0_setup: SETUP_RST, w1_setup: SETUP_RST, w0_base: '0, w1_base: '0,
                                       w0_tbase: 32'h0, w1_tbase: 32'h0, bus: BUS_IDLE, addr: 8'h00,
                                       rdata: 32'h0};

endpackage : bbs_pkg

// ### design/bbs_mask.sv
// Writable-bit mask of a window base-address field, derived from the aperture size
`timescale 1ns/1ns
module bbs_mask import bbs_pkg::*; (
  input wire logic [5:0] size,
  input wire logic wide,
  output logic [BASE_BITS-1:0] writable
);

  logic [5:0] eff_size;

  // Without 64-bit addressing a size above 32 only counts up to 32
  always_comb begin
    eff_size = (!wide && (size > SIZE_CAP32)) ? SIZE_CAP32 : size;
  end

  // ----------------------------------------------------------------
  // One mask bit per base-address bit, address bit = index + 4
  // ----------------------------------------------------------------
  for (genvar i = 0; i < BASE_BITS; i++) begin : g_bit
    localparam logic [6:0] ADDR_BIT = 7'(i + BASE_LSB);
    localparam logic IN_LOW = (i < LOW_BITS);
    assign writable[i] = (wide | IN_LOW) & ((size == SIZE_ALL) |
                         ((size >= SIZE_MIN_ON) & ({1'b0, eff_size} <= ADDR_BIT)));
  end

endmodule : bbs_mask

// ### tb/tb_top.sv
// Self-checking testbench of the window setup register bank
`timescale 1ns/1ns
module tb_top import bbs_pkg::*;;
  logic clk, rst, cold_rst, hsel, hwrite, hreadyout, hresp, pair_mode;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  bbs_win_t win0, win1;
  int err_count, checks;
  logic [5:0] corner [10] = '{6'h00, 6'h01, 6'h03, 6'h04, 6'h05, 6'h07, 6'h1F, 6'h20, 6'h21, 6'h3F};

  bbs_setup_bank uut (.clk(clk), .rst(rst), .cold_rst(cold_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .pair_mode(pair_mode), .win0(win0), .win1(win1));

  // ----------------------------------------------------------------
  // Clock, watchdog and verdict
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Whole run needs well under 1000 cycles; the margin covers slow answers
  initial begin
    repeat (6000) @(posedge clk);
    err_count++;
    close_out();
  end

  task automatic close_out();
    $display("counts: %0d comparisons, %0d mismatches", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  // ----------------------------------------------------------------
  // Bus master and comparison helpers
  // ----------------------------------------------------------------
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      err_count++;
    end
  endtask : chk

  // Called right after a rising edge; every change lands by non-blocking assignment
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h000000, a};
    hwrite <= wr;
    hsize <= 3'h2;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 50) begin
      @(posedge clk);
      n++;
    end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rd = hrdata;
    chk("hresp", 32'h0, {31'h0, hresp});
    if (n >= 50) begin
      $display("mismatch bus answer expected ready seen none");
      err_count++;
    end
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask : wr

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string name);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(name, exp, x);
  endtask : rd_chk

  // Writable address bits 31:4 of a base field in 32-bit decoding
  function automatic logic [31:0] base_mask(input logic [5:0] sz);
    logic [31:0] m;
    int e;
    m = 32'h0;
    e = (sz > 6'h20) ? 32 : int'(sz);
    for (int a = 4; a < 32; a++) begin
      if (sz == 6'h00 || (sz >= 6'h04 && a >= e)) m[a] = 1'b1;
    end
    return m;
  endfunction : base_mask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [31:0] d, m;
    logic [5:0] sz;
    logic [1:0] w, wexp;
    logic p, sp;
    rst = 1'b1;
    cold_rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    err_count = 0;
    checks = 0;
    void'($urandom(44770));
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    cold_rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFS_W0_SETUP, 32'h00000010, "setup0 reset");
    rd_chk(OFS_W1_SETUP, 32'h00000010, "setup1 reset");
    rd_chk(OFS_W0_BASE, 32'h0, "base0 disabled");
    rd_chk(OFS_W1_TBASE, 32'h0, "tbase1 reset");
    wr(8'h40, 32'hFFFFFFFF);
    rd_chk(8'h40, 32'h0, "unmapped");
    $display("test reset done");
    // Memory space here: an all-ones size on an I/O window would break the software size limits
    wr(OFS_W0_SETUP, 32'hFFFFFFFE);
    rd_chk(OFS_W0_SETUP, 32'h800003FE, "setup0 fields");
    $display("test fields done");
    // Corner sizes first, then random ones; width 2 is left to the pairing test
    for (int i = 0; i < 24; i++) begin
      sz = (i < 10) ? corner[i] : 6'($urandom_range(0, 63));
      p = 1'($urandom());
      // Software keeps memory windows at 128 bytes or more and I/O windows at 256 bytes or less
      sp = (sz != 6'h00 && sz < 6'h07) ? 1'b1 : (sz > 6'h08 || sz == 6'h00) ? 1'b0 : 1'($urandom());
      w = (($urandom() & 1) != 0) ? 2'h1 : (($urandom() & 1) != 0) ? 2'h3 : 2'h0;
      wexp = sp ? 2'h0 : w;
      d = $urandom();
      m = base_mask(sz);
      wr(OFS_W0_SETUP, {1'b1, 21'h0, sz, p, w, sp});
      rd_chk(OFS_W0_SETUP, {1'b1, 21'h0, sz, p, wexp, sp}, "setup0 rw");
      chk("pair off", 32'h0, {31'h0, pair_mode});
      wr(OFS_W0_BASE, d);
      rd_chk(OFS_W0_BASE, (d & m) | {28'h0, p, wexp, sp}, "base0 mask");
      chk("win0 base", d & m, win0.base[31:0]);
      chk("win0 type", {28'h0, p, wexp, sp}, {28'h0, win0.pref, win0.width, win0.space});
    end
    $display("test masking done");
    wr(OFS_W0_SETUP, 32'h00000000);
    wr(OFS_W0_BASE, 32'hFFFFFFFF);
    rd_chk(OFS_W0_BASE, 32'h0, "base0 off");
    chk("win0 en", 32'h0, {31'h0, win0.en});
    $display("test disable done");
    wr(OFS_W0_SETUP, 32'h80000004);
    // The write lands at the edge that ends the task; look one edge later
    @(posedge clk);
    chk("pair on", 32'h1, {31'h0, pair_mode});
    wr(OFS_W1_TBASE, 32'hFFFFFFFF);
    rd_chk(OFS_W1_TBASE, 32'hFFFFFFFF, "tbase1 pair");
    chk("win0 tbase hi", 32'hFFFFFFFF, win0.tbase[63:32]);
    wr(OFS_W1_SETUP, 32'hFFFFFFFF);
    rd_chk(OFS_W1_SETUP, 32'h0, "setup1 pair");
    chk("win1 en", 32'h0, {31'h0, win1.en});
    d = $urandom();
    wr(OFS_W1_BASE, d);
    rd_chk(OFS_W1_BASE, d, "base0 upper");
    chk("win0 base hi", d, win0.base[63:32]);
    wr(OFS_W0_SETUP, 32'h80000000);
    rd_chk(OFS_W1_TBASE, 32'hFFFFFFF0, "tbase1 normal");
    rd_chk(OFS_W1_SETUP, 32'h00000010, "setup1 kept");
    $display("test pairing done");
    wr(OFS_W0_SETUP, 32'h80000078);
    wr(OFS_W0_TBASE, 32'h12345670);
    wr(OFS_W1_SETUP, 32'h8000004F);
    rd_chk(OFS_W1_SETUP, 32'h80000049, "setup1 io");
    wr(OFS_W1_BASE, 32'hFFFFFFFF);
    rd_chk(OFS_W1_BASE, 32'hFFFFFFF9, "base1 io16");
    chk("win1 base", 32'hFFFFFFF0, win1.base[31:0]);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd_chk(OFS_W0_SETUP, 32'h80000018, "setup0 sticky");
    rd_chk(OFS_W1_SETUP, 32'h80000019, "setup1 sticky");
    rd_chk(OFS_W0_TBASE, 32'h12345670, "tbase0 sticky");
    rd_chk(OFS_W1_BASE, 32'h00000009, "base1 after");
    $display("test hot reset done");
    close_out();
  end
endmodule : tb_top
